// File: verilog/cidt_core_decode.v
// instruction decode and execution-timing front end of the core
// Function
// RULE1 - recognise the base set and the eight extended instructions
// RULE2 - one word per instruction except four double-word instructions
// RULE3 - split each word into opcode and operand fields
// RULE4 - sort instructions into byte, bit, literal and control classes
// RULE5 - byte ops carry register address, destination and access fields
// RULE6 - destination zero writes working register, one writes file
// RULE7 - bit ops carry register address, bit number and access fields
// RULE8 - literal ops carry constant, pointer selector or nothing
// RULE9 - control ops carry address, fast bit, table mode or nothing
// RULE10 - double words hold 32 bits, second word top nibble ones
// RULE11 - second word executed alone acts as no-operation
// RULE12 - one cycle, two when test true or counter changed
// RULE13 - double-word instructions take two cycles
// RULE14 - one instruction cycle is four oscillator periods
// RULE15 - taken two-word branch takes three cycles in total
// RULE16 - access bit zero uses access region, one uses bank selector
// RULE17 - table mode picks none, post-inc, post-dec or pre-inc
// RULE18 - fast bit one saves or restores shadows, zero leaves them; a call saves only with top byte ed and bit 0 also set
// RULE19 - on counter change discard prefetch and run a nop slot
`timescale 1ns/1ns
`include "cidt_consts.vh"

module cidt_core_decode (
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// fetch path and datapath status
	input wire [15:0] fetch_word,
	input wire cond_true,
	input wire pc_write,
	input wire [3:0] ram_bank_selector,
	// timing
	output reg [1:0] q_phase,
	output reg cycle_start,
	output reg prefetch_discard,
	// slot state
	output reg exec_valid,
	output reg exec_nop,
	output reg second_word,
	output reg [1:0] op_class,
	output reg ext_instr,
	// byte and bit operands
	output reg [7:0] file_addr,
	output reg [11:0] ram_addr,
	output reg access_banked,
	output reg wr_working_register,
	output reg wr_file,
	output reg [2:0] bit_num,
	// literal operands
	output reg [7:0] literal,
	output reg [1:0] indirect_pointer_sel,
	// control operands
	output reg [19:0] prog_addr,
	output reg shadow_save,
	output reg shadow_restore,
	output reg table_op,
	output reg [1:0] table_pointer_mode
);

	reg [1:0] state;
	reg [15:0] exec_word;
	reg cur_dbl;
	reg cur_dbl_branch;
	reg cur_jump;
	reg cur_cond;
	reg [1:0] next_state;
	reg [15:0] next_word;
	reg next_nop;
	reg next_second;
	reg next_discard;
	wire cyc_end;
	wire [1:0] d_class;
	wire d_dbl;
	wire d_dbl_branch;
	wire d_word2;
	wire d_ext;
	wire d_jump;
	wire d_cond;
	wire d_save;
	wire d_restore;
	wire d_tbl;

	// RULE14 - four phases per cycle
	assign cyc_end = (q_phase == `CIDT_Q_LAST);

	// decode of the word about to enter execution
	cidt_field_decode u_dec (
		.word(next_word),
		.op_class(d_class),
		.dbl_first(d_dbl),
		.dbl_branch(d_dbl_branch),
		.is_word2(d_word2),
		.is_ext(d_ext),
		.jump(d_jump),
		.cond_cand(d_cond),
		.shadow_save(d_save),
		.shadow_restore(d_restore),
		.tbl_op(d_tbl)
	);

	// slot sequencing for the next instruction cycle
	always @* begin
		next_state = `CIDT_ST_RUN;
		next_word = fetch_word;
		next_nop = 1'b0;
		next_second = 1'b0;
		next_discard = 1'b0;
		case (state)
		`CIDT_ST_RUN: begin
			if (cur_dbl) begin
				// RULE13 - second word fills cycle two
				next_state = `CIDT_ST_WORD2;
				next_second = 1'b1;
			end else if (cur_jump || pc_write ||
			             (cur_cond && cond_true)) begin
				// RULE12 - added cycle as nop
				// RULE19 - drop the prefetched word
				next_state = `CIDT_ST_NOP;
				next_nop = 1'b1;
				next_discard = 1'b1;
				next_word = 16'h0000;
			end
		end
		`CIDT_ST_WORD2: begin
			if (cur_dbl_branch || pc_write) begin
				// RULE15 - third cycle for taken branch
				next_state = `CIDT_ST_NOP;
				next_nop = 1'b1;
				next_discard = 1'b1;
				next_word = 16'h0000;
			end
		end
		`CIDT_ST_NOP: begin
			next_state = `CIDT_ST_RUN;
		end
		default: begin
			next_state = `CIDT_ST_RUN;
		end
		endcase
	end

	// phase counter and cycle start pulse
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			q_phase <= 2'h0;
			cycle_start <= 1'b0;
		end else begin
			q_phase <= q_phase + 2'h1;
			cycle_start <= cyc_end;
		end
	end

	// sequencer state and the flags of the running instruction
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= `CIDT_ST_NOP;
			exec_word <= 16'h0000;
			cur_dbl <= 1'b0;
			cur_dbl_branch <= 1'b0;
			cur_jump <= 1'b0;
			cur_cond <= 1'b0;
			exec_valid <= 1'b0;
			exec_nop <= 1'b1;
			second_word <= 1'b0;
			prefetch_discard <= 1'b0;
		end else if (cyc_end) begin
			state <= next_state;
			exec_word <= next_word;
			exec_valid <= 1'b1;
			exec_nop <= next_nop;
			second_word <= next_second;
			prefetch_discard <= next_discard;
			if (next_state == `CIDT_ST_RUN) begin
				// RULE11 - stray second word decodes inert
				cur_dbl <= d_dbl && !d_word2;
				cur_dbl_branch <= d_dbl_branch;
				cur_jump <= d_jump;
				cur_cond <= d_cond;
			end else begin
				cur_dbl <= 1'b0;
				cur_jump <= 1'b0;
				cur_cond <= 1'b0;
			end
		end else begin
			prefetch_discard <= 1'b0;
		end
	end

	// operand fields of the instruction entering execution
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			op_class <= `CIDT_CLS_CTRL;
			ext_instr <= 1'b0;
			file_addr <= 8'h00;
			ram_addr <= 12'h000;
			access_banked <= 1'b0;
			wr_working_register <= 1'b0;
			wr_file <= 1'b0;
			bit_num <= 3'h0;
			literal <= 8'h00;
			indirect_pointer_sel <= 2'h0;
			prog_addr <= 20'h00000;
			shadow_save <= 1'b0;
			shadow_restore <= 1'b0;
			table_op <= 1'b0;
			table_pointer_mode <= `CIDT_TBL_NONE;
		end else if (cyc_end) begin
			// defaults: no side effect in this slot
			wr_working_register <= 1'b0;
			wr_file <= 1'b0;
			shadow_save <= 1'b0;
			shadow_restore <= 1'b0;
			table_op <= 1'b0;
			ext_instr <= 1'b0;
			if (next_second) begin
				// RULE10 - 20-bit target from both words
				prog_addr <= {next_word[11:0], exec_word[7:0]};
			end else if (!next_nop && !d_word2) begin
				// RULE3 - opcode and operand split
				op_class <= d_class;
				// RULE1 - flag extended set
				ext_instr <= d_ext;
				// RULE5 - register address field
				// RULE7 - address for bit ops
				file_addr <= next_word[7:0];
				// RULE16 - access bit picks region
				access_banked <= next_word[8];
				if (next_word[8])
					ram_addr <= {ram_bank_selector, next_word[7:0]};
				else if (next_word[7:0] < `CIDT_ACCESS_SPLIT)
					ram_addr <= {`CIDT_ACCESS_LOW, next_word[7:0]};
				else
					ram_addr <= {`CIDT_ACCESS_HIGH, next_word[7:0]};
				// RULE6 - destination select
				if (d_class == `CIDT_CLS_BYTE &&
				    next_word[15:12] != `CIDT_OP_MOVE2) begin
					wr_working_register <= !next_word[9];
					wr_file <= next_word[9];
				end
				// RULE7 - bit number field
				bit_num <= next_word[11:9];
				// RULE8 - constant and pointer selector
				literal <= next_word[7:0];
				indirect_pointer_sel <= next_word[5:4];
				// RULE9 - single-word branch targets
				if (next_word[15:11] == `CIDT_OP_BRA ||
				    next_word[15:11] == `CIDT_OP_RCALL)
					prog_addr <= {{9{next_word[10]}}, next_word[10:0]};
				else if (next_word[15:11] == `CIDT_OP_CONDBR)
					prog_addr <= {{12{next_word[7]}}, next_word[7:0]};
				// RULE18 - shadow copies on fast mode
				shadow_save <= d_save;
				shadow_restore <= d_restore;
				// RULE17 - table pointer update mode
				table_op <= d_tbl;
				table_pointer_mode <= next_word[1:0];
			end
		end else begin
			// side-effect strobes last one phase
			wr_working_register <= 1'b0;
			wr_file <= 1'b0;
			shadow_save <= 1'b0;
			shadow_restore <= 1'b0;
			table_op <= 1'b0;
		end
	end

endmodule // cidt_core_decode

// File: verilog/cidt_consts.vh
// constants for the instruction decode and timing front end
`ifndef CIDT_CONSTS_VH
`define CIDT_CONSTS_VH

// oscillator periods in one instruction cycle
`define CIDT_Q_PER_CYCLE 3'h4
`define CIDT_Q_LAST 2'h3

// operation classes
`define CIDT_CLS_BYTE 2'h0
`define CIDT_CLS_BIT 2'h1
`define CIDT_CLS_LIT 2'h2
`define CIDT_CLS_CTRL 2'h3

// sequencer states
`define CIDT_ST_RUN 2'h0
`define CIDT_ST_WORD2 2'h1
`define CIDT_ST_NOP 2'h2

// top nibble of a second word: always all ones
`define CIDT_WORD2_TAG 4'hf

// top-byte and top-nibble opcodes of the double-word group
`define CIDT_OP_CALL0 8'hec
`define CIDT_OP_CALL1 8'hed
`define CIDT_OP_LOADPTR 8'hee
`define CIDT_OP_GOTO 8'hef
`define CIDT_OP_MOVE2 4'hc

// single-word opcodes for control, skip, table, bank literal and extended set
`define CIDT_OP_BRA 5'h1a
`define CIDT_OP_RCALL 5'h1b
`define CIDT_OP_CONDBR 5'h1c
`define CIDT_OP_EXTSET 6'h3a
`define CIDT_OP_SKIPBIT0 4'ha
`define CIDT_OP_SKIPBIT1 4'hb
`define CIDT_OP_RETI 7'h08
`define CIDT_OP_RETURN 7'h09
`define CIDT_OP_TABLE 5'h01
`define CIDT_OP_BANKLIT 8'h01
`define CIDT_OP_SPECIAL 8'h00

// access region split for unbanked operands
`define CIDT_ACCESS_SPLIT 8'h60
`define CIDT_ACCESS_HIGH 4'hf
`define CIDT_ACCESS_LOW 4'h0

// table pointer update modes
`define CIDT_TBL_NONE 2'h0
`define CIDT_TBL_POSTINC 2'h1
`define CIDT_TBL_POSTDEC 2'h2
`define CIDT_TBL_PREINC 2'h3

`endif

// File: verilog/cidt_field_decode.v
// combinational class and flag decode of one program word
`timescale 1ns/1ns
`include "cidt_consts.vh"

module cidt_field_decode (
	// word under decode
	input wire [15:0] word,
	// class and sequencing flags
	output reg [1:0] op_class,
	output reg dbl_first,
	output reg dbl_branch,
	output reg is_word2,
	output reg is_ext,
	output reg jump,
	output reg cond_cand,
	// operation flags
	output reg shadow_save,
	output reg shadow_restore,
	output reg tbl_op
);

	// classify by the opcode portion in the upper bits
	always @* begin
		op_class = `CIDT_CLS_CTRL;
		dbl_first = 1'b0;
		dbl_branch = 1'b0;
		is_word2 = 1'b0;
		is_ext = 1'b0;
		jump = 1'b0;
		cond_cand = 1'b0;
		shadow_save = 1'b0;
		shadow_restore = 1'b0;
		tbl_op = 1'b0;
		// RULE4 - four class split
		case (word[15:12])
		4'h0: begin
			if (word[15:8] == `CIDT_OP_BANKLIT ||
			    word[11:8] >= 4'h8)
				op_class = `CIDT_CLS_LIT;
			else if (word[15:8] != `CIDT_OP_SPECIAL)
				op_class = `CIDT_CLS_BYTE;
		end
		4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
			op_class = `CIDT_CLS_BYTE;
		4'h7, 4'h8, 4'h9, 4'ha, 4'hb:
			op_class = `CIDT_CLS_BIT;
		4'hc:
			op_class = `CIDT_CLS_BYTE;
		4'he:
			if (word[15:8] == `CIDT_OP_LOADPTR)
				op_class = `CIDT_CLS_LIT;
		default:
			op_class = `CIDT_CLS_CTRL;
		endcase
		// RULE2 - four double-word forms
		if (word[15:12] == `CIDT_OP_MOVE2 ||
		    word[15:8] == `CIDT_OP_CALL0 ||
		    word[15:8] == `CIDT_OP_CALL1 ||
		    word[15:8] == `CIDT_OP_LOADPTR ||
		    word[15:8] == `CIDT_OP_GOTO)
			dbl_first = 1'b1;
		// RULE15 - two-word branches
		if (word[15:8] == `CIDT_OP_CALL0 ||
		    word[15:8] == `CIDT_OP_CALL1 ||
		    word[15:8] == `CIDT_OP_GOTO)
			dbl_branch = 1'b1;
		// RULE11 - lone second word is nop
		is_word2 = (word[15:12] == `CIDT_WORD2_TAG);
		// RULE1 - extended set marker
		is_ext = (word[15:10] == `CIDT_OP_EXTSET);
		// RULE12 - program counter changers
		if (word[15:11] == `CIDT_OP_BRA || word[15:11] == `CIDT_OP_RCALL)
			jump = 1'b1;
		if (word[15:8] == `CIDT_OP_SPECIAL &&
		    (word[7:1] == `CIDT_OP_RETI || word[7:1] == `CIDT_OP_RETURN))
			jump = 1'b1;
		// RULE12 - conditional tests
		cond_cand = (word[15:11] == `CIDT_OP_CONDBR) ||
			(word[15:12] == `CIDT_OP_SKIPBIT0) ||
			(word[15:12] == `CIDT_OP_SKIPBIT1);
		// RULE18 - fast bit picks shadows
		if (word[0] && (word[15:8] == `CIDT_OP_CALL1))
			shadow_save = 1'b1;
		if (word[0] && word[15:8] == `CIDT_OP_SPECIAL &&
		    (word[7:1] == `CIDT_OP_RETI || word[7:1] == `CIDT_OP_RETURN))
			shadow_restore = 1'b1;
		// RULE17 - table access group
		tbl_op = (word[15:8] == `CIDT_OP_SPECIAL) &&
			(word[7:3] == `CIDT_OP_TABLE);
	end

endmodule // cidt_field_decode

// File: verification/cidt_core_decode_sva.sv
// checker for the decode and timing front end
`timescale 1ns/1ns
module cidt_core_decode_sva (
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// datapath inputs
	input wire cond_true,
	input wire pc_write,
	input wire [3:0] ram_bank_selector,
	// timing and slot outputs
	input wire [1:0] q_phase,
	input wire cycle_start,
	input wire prefetch_discard,
	input wire exec_valid,
	input wire exec_nop,
	input wire second_word,
	input wire [1:0] op_class,
	// operand outputs
	input wire [7:0] file_addr,
	input wire [11:0] ram_addr,
	input wire access_banked,
	input wire wr_working_register,
	input wire wr_file,
	input wire shadow_save,
	input wire shadow_restore,
	input wire table_op
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// any one-clock action strobe
	wire strobe = wr_working_register | wr_file | shadow_save |
		shadow_restore | table_op;
	// a slot that changes flow or skips
	sequence s_flush_req;
		q_phase == 2'h3 && exec_valid && !exec_nop && !second_word &&
			(pc_write || cond_true);
	endsequence
	// the inserted empty slot
	sequence s_nop_slot;
		cycle_start && exec_nop && prefetch_discard;
	endsequence
	AST_PHASE_STEP: assert property (1'b1 |=>
		q_phase == $past(q_phase) + 2'h1) else $error("phase step");
	AST_CYCLE_START: assert property (exec_valid |->
		cycle_start == (q_phase == 2'h0)) else $error("cycle start");
	AST_DEST_ONE: assert property (!(wr_working_register && wr_file))
		else $error("two destinations");
	AST_STROBE: assert property (strobe |-> q_phase == 2'h0 ##1 !strobe)
		else $error("strobe width");
	AST_FIELD_HOLD: assert property (q_phase != 2'h0 |->
		$stable(file_addr) && $stable(op_class)) else $error("field moved");
	AST_FLUSH: assert property (s_flush_req |=> s_nop_slot)
		else $error("no flush slot");
	AST_NOP_QUIET: assert property (exec_nop |-> !strobe)
		else $error("strobe in nop");
	AST_BANKED: assert property (cycle_start && access_banked &&
		!exec_nop && !second_word && op_class <= 2'h1 |->
		ram_addr == {$past(ram_bank_selector), file_addr})
		else $error("banked address");
endmodule // cidt_core_decode_sva

bind cidt_core_decode cidt_core_decode_sva chk_u (
	.core_clk(core_clk),
	.arst_n(arst_n),
	.cond_true(cond_true),
	.pc_write(pc_write),
	.ram_bank_selector(ram_bank_selector),
	.q_phase(q_phase),
	.cycle_start(cycle_start),
	.prefetch_discard(prefetch_discard),
	.exec_valid(exec_valid),
	.exec_nop(exec_nop),
	.second_word(second_word),
	.op_class(op_class),
	.file_addr(file_addr),
	.ram_addr(ram_addr),
	.access_banked(access_banked),
	.wr_working_register(wr_working_register),
	.wr_file(wr_file),
	.shadow_save(shadow_save),
	.shadow_restore(shadow_restore),
	.table_op(table_op)
);

// File: verification/cidt_prog_mem.sv
// program memory model: one word per instruction cycle
`timescale 1ns/1ns
module cidt_prog_mem (
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// decoder timing
	input wire [1:0] q_phase,
	input wire exec_valid,
	// word to the decoder
	output wire [15:0] fetch_word
);
	logic [15:0] mem [0:27] = '{16'h245f, 16'h2460, 16'h2785, 16'h8b55,
		16'h0e3c, 16'hee20, 16'hf0ab, 16'hef12, 16'hf345, 16'h2470,
		16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'hd7fb, 16'h2470,
		16'hb055, 16'h2470, 16'hf123, 16'hed01, 16'hf000, 16'h2470,
		16'h0013, 16'h2470, 16'h0012, 16'h2470, 16'he805, 16'h0000};
	logic [4:0] ptr;
	always @(negedge core_clk or negedge arst_n) begin
		if (!arst_n)
			ptr <= 5'h0;
		else if (q_phase == 2'h0 && exec_valid && ptr != 5'h1b)
			ptr <= ptr + 5'h1;
	end
	assign fetch_word = mem[ptr];
endmodule // cidt_prog_mem

// File: verification/core_instruction_decode_timing_bench.sv
// self-checking bench for the decode and timing front end
`timescale 1ns/1ns
module core_instruction_decode_timing_bench;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic cond_true = 1'b0;
	logic pc_write = 1'b0;
	logic [3:0] ram_bank_selector = 4'h3;
	wire [15:0] fetch_word;
	wire [1:0] q_phase, op_class, indirect_pointer_sel, table_pointer_mode;
	wire cycle_start, prefetch_discard, exec_valid, exec_nop, second_word;
	wire ext_instr, access_banked, wr_working_register, wr_file;
	wire shadow_save, shadow_restore, table_op;
	wire [7:0] file_addr, literal;
	wire [11:0] ram_addr;
	wire [2:0] bit_num;
	wire [19:0] prog_addr;
	int err_total = 0;
	int checks = 0;
	always #5 core_clk = ~core_clk;
	cidt_core_decode dut_u (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.fetch_word(fetch_word),
		.cond_true(cond_true),
		.pc_write(pc_write),
		.ram_bank_selector(ram_bank_selector),
		.q_phase(q_phase),
		.cycle_start(cycle_start),
		.prefetch_discard(prefetch_discard),
		.exec_valid(exec_valid),
		.exec_nop(exec_nop),
		.second_word(second_word),
		.op_class(op_class),
		.ext_instr(ext_instr),
		.file_addr(file_addr),
		.ram_addr(ram_addr),
		.access_banked(access_banked),
		.wr_working_register(wr_working_register),
		.wr_file(wr_file),
		.bit_num(bit_num),
		.literal(literal),
		.indirect_pointer_sel(indirect_pointer_sel),
		.prog_addr(prog_addr),
		.shadow_save(shadow_save),
		.shadow_restore(shadow_restore),
		.table_op(table_op),
		.table_pointer_mode(table_pointer_mode)
	);
	cidt_prog_mem mem_u (.core_clk, .arst_n, .q_phase, .exec_valid,
		.fetch_word);
	// compare one value
	task chk(input string name, input logic [19:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// wait for the next slot start; look after outputs have settled
	task automatic slot;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (cycle_start !== 1'b1 && n < 9);
		if (n >= 9)
			chk("slot", 20'h0, 20'h1);
	endtask
	// datapath status for the running slot
	task flag(input logic c, p);
		@(negedge core_clk);
		cond_true = c;
		pc_write = p;
	endtask
	task t_reset;
		chk("q_phase", q_phase, 20'h0); // idle
		chk("exec_nop", exec_nop, 20'h1); // idle
		chk("valid", exec_valid, 20'h0); // idle
	endtask
	task t_byte;
		slot;
		chk("class", op_class, 20'h0); // byte
		chk("wr_w", wr_working_register, 20'h1); // d zero
		chk("ram", ram_addr, 20'h05f); // low access
		chk("bank", access_banked, 20'h0); // access bit
		slot;
		chk("ram", ram_addr, 20'hf60); // high access
		slot;
		chk("wr_f", wr_file, 20'h1); // d one
		chk("file", file_addr, 20'h85); // address
		flag(1'b0, 1'b0);
		ram_bank_selector = 4'ha;
	endtask
	task t_bit_lit;
		slot;
		chk("class", op_class, 20'h1); // bit
		chk("bit", bit_num, 20'h5); // bit number
		chk("ram", ram_addr, 20'ha55); // banked
		chk("bank", access_banked, 20'h1); // bank bit
		slot;
		chk("class", op_class, 20'h2); // literal
		chk("lit", literal, 20'h3c); // constant
	endtask
	task t_double;
		slot;
		chk("ptr_sel", indirect_pointer_sel, 20'h2); // pointer
		slot;
		chk("word2", second_word, 20'h1); // pair
		slot;
		chk("nop", exec_nop, 20'h0); // two cycles
		slot;
		chk("target", prog_addr, 20'h34512); // 20-bit target
		flag(1'b0, 1'b1);
		slot;
		chk("nop", exec_nop, 20'h1); // third cycle
		chk("drop", prefetch_discard, 20'h1); // discard
		flag(1'b0, 1'b0);
	endtask
	task t_table;
		for (int i = 0; i < 4; i++) begin
			slot;
			chk("tbl", table_op, 20'h1); // table
			chk("mode", table_pointer_mode, i); // mode
		end
	endtask
	task t_branch;
		slot;
		chk("target", prog_addr, 20'hffffb); // signed offset
		flag(1'b0, 1'b1);
		slot;
		chk("nop", exec_nop, 20'h1); // taken jump
		flag(1'b0, 1'b0);
		slot;
		flag(1'b1, 1'b0);
		slot;
		chk("nop", exec_nop, 20'h1); // true test
		flag(1'b0, 1'b0);
		slot;
		chk("quiet", {wr_working_register, wr_file, table_op}, 20'h0);
		chk("word2", second_word, 20'h0); // lone word
	endtask
	task t_call;
		slot;
		chk("save", shadow_save, 20'h1); // fast call
		slot;
		flag(1'b0, 1'b1);
		slot;
		chk("nop", exec_nop, 20'h1); // call cycles
		flag(1'b0, 1'b0);
		slot;
		chk("restore", shadow_restore, 20'h1); // fast return
		flag(1'b0, 1'b1);
		slot;
		flag(1'b0, 1'b0);
		slot;
		chk("restore", shadow_restore, 20'h0); // plain return
		slot;
		chk("nop", exec_nop, 20'h1); // return flush
		slot;
		chk("ext", ext_instr, 20'h1); // extended
		slot;
		chk("ext", ext_instr, 20'h0); // base
	endtask
	// print counts and verdict, then stop
	task finish_test;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (20) @(negedge core_clk);
		t_reset;
		arst_n = 1'b1;
		t_byte;
		t_bit_lit;
		t_double;
		t_table;
		t_branch;
		t_call;
		finish_test;
	end
	// about 30 slots of 40 ns after reset; far beyond that is a hang
	initial begin
		#5000;
		err_total++;
		finish_test;
	end
endmodule // core_instruction_decode_timing_bench
